/* rtl/crss_pkg.sv */
// crss_pkg: shared constants for the charger register serial target port
// assumes a single 50 MHz system clock; no software-visible registers
`default_nettype none
package crss_pkg;
  // --------------------------------------------------------------
  // addressing and register bank
  // --------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR      = 7'h6b;
  localparam int         REG_COUNT        = 12;
  localparam logic [7:0] LAST_REG_INDEX   = 8'h0b;
  localparam logic [7:0] FAULT_REG_INDEX  = 8'h09;
  localparam logic [7:0] UNMAPPED_READ    = 8'hff;
  localparam logic [7:0] REG_RESET        = 8'h00;
  // --------------------------------------------------------------
  // timing: bus bit rates against the system clock
  // --------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int FAST_BPS      = 400_000;
  localparam int STD_BPS       = 100_000;
  localparam int FAST_BIT_CYC  = CLK_HZ / FAST_BPS;
  localparam int FIFO_DEPTH    = 8;
  localparam int DATA_W        = 8;
  // --------------------------------------------------------------
  // receive engine states, gray along the usual path
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    CRSS_IDLE  = 3'b000,
    CRSS_ADDR  = 3'b001,
    CRSS_AACK  = 3'b011,
    CRSS_RXB   = 3'b010,
    CRSS_RACK  = 3'b110,
    CRSS_TXB   = 3'b111,
    CRSS_TACK  = 3'b101
  } crss_state_e;
endpackage
`default_nettype wire

/* rtl/crss_sync.sv */
// crss_sync: two-flop synchroniser for one pin input
// assumes the pin is asynchronous to clock; output is registered
`default_nettype none
module crss_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clock,   // system clock
  input  wire logic reset_n, // async reset, active low
  input  wire logic ce,      // clock enable
  input  wire logic d,       // async level
  output var  logic q        // synchronised level
);
  logic meta_r;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end
    else if (ce)
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* rtl/crss_fifo.sv */
// crss_fifo: small flop-based fifo with valid/ready on both sides
// assumes one clock; push and pop may occur in the same cycle
`default_nettype none
module crss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,    // system clock
  input  wire logic             reset_n,  // async reset, active low
  input  wire logic             ce,       // clock enable
  input  wire logic             clear,    // drop all contents
  input  wire logic             in_valid, // write request
  output var  logic             in_ready, // space available
  input  wire logic [WIDTH-1:0] in_data,  // write word
  output var  logic             out_valid,// word available
  input  wire logic             out_ready,// read accept
  output var  logic [WIDTH-1:0] out_data  // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock)
  begin
    if (ce && push)
      mem_r[wptr_r] <= in_data;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end
    else if (ce)
    begin
      if (clear)
      begin
        wptr_r  <= '0;
        rptr_r  <= '0;
        count_r <= '0;
      end
      else
      begin
        if (push)
          wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
        if (pop)
          rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
        if (push && !pop)
          count_r <= count_r + 1'b1;
        else if (pop && !push)
          count_r <= count_r - 1'b1;
      end
    end
  end

  // occupancy must step up by one on a push without a pop, not merely stay in range
  a_fifo_count_step : assert property (@(posedge clock) disable iff (!reset_n)
    ce && !clear && push && !pop |=> count_r == $past(count_r) + 1'b1)
    else $error("fifo count did not step on push");
endmodule
`default_nettype wire

/* rtl/crss_target.sv */
// crss_target: two-wire serial target port with a twelve-byte register bank
// assumes bus lines are pulled up outside; clock samples both lines
// Function
// - answer only the fixed 7-bit target address; ignore other targets
// - twelve 8-bit registers 0x00..0x0b; reads above return 0xff
// - work at 100 kbit/s and 400 kbit/s bus rates
// - lines driven low or released only; idle bus is high
// - start is data falling with clock high; stop is data rising
// - transmitter changes data only while clock is low
// - bytes of eight bits, most significant bit first, unlimited count
// - receiver drives ninth bit low to acknowledge; transmitter releases
// - first byte holds address and direction bit, one means read
// - direction fixed until repeated start or stop
// - bytes after the index are stored at increasing indices
// - read returns selected register, next one after each acknowledge
// - undefined register index gets not acknowledge and idles the port
// - auto increment skips the fault status register
// - fault history holds until read; the read reloads it with the live faults
`default_nettype none
module crss_target #(
  parameter logic [6:0] TARGET_ADDR = crss_pkg::TARGET_ADDR
) (
  input  wire logic       clock,       // 50 MHz system clock
  input  wire logic       reset_n,     // async reset, active low
  input  wire logic       ce,          // clock enable, freezes state
  input  wire logic       scl_in,      // bus clock pin level
  output var  logic       scl_out,     // bus clock drive value, always low
  output var  logic       scl_oe_n,    // bus clock enable, low drives
  input  wire logic       sda_in,      // bus data pin level
  output var  logic       sda_out,     // bus data drive value, always low
  output var  logic       sda_oe_n,    // bus data enable, low drives
  input  wire logic [7:0] fault_live,  // active fault conditions
  output var  logic       busy,        // bus busy between start and stop
  output var  logic [7:0] reg_index,   // current register index
  output var  logic       wr_strobe,   // one-cycle pulse per stored byte
  output var  logic [7:0] wr_data      // byte stored with wr_strobe
);
  // --------------------------------------------------------------
  // pin sampling and edge detection
  // --------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  crss_sync #(.RST_VAL(1'b1)) u_scl_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .ce      (ce),
    .d       (scl_in),
    .q       (scl_s)
  );
  crss_sync #(.RST_VAL(1'b1)) u_sda_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .ce      (ce),
    .d       (sda_in),
    .q       (sda_s)
  );

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else if (ce)
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // sampling at 50 MHz gives 125 samples per fast-mode bit; ample margin
  assign scl_rise  = scl_s && !scl_d_r;
  assign scl_fall  = !scl_s && scl_d_r;
  assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_det  = scl_s && scl_d_r && !sda_d_r && sda_s;

  // --------------------------------------------------------------
  // index stepping
  // --------------------------------------------------------------
  function automatic logic [7:0] next_index(input logic [7:0] idx);
    logic [7:0] n;
    n = idx + 8'h01;
    if (n == crss_pkg::FAULT_REG_INDEX)
      n = n + 8'h01;
    return n;
  endfunction

  // --------------------------------------------------------------
  // register bank
  // --------------------------------------------------------------
  logic [7:0]  bank_r [crss_pkg::REG_COUNT];
  logic [7:0]  fault_hist_r;
  logic [7:0]  rd_byte;
  logic        fault_rd_pulse;
  logic        wr_pulse;
  logic [7:0]  wr_byte;

  always_comb
  begin
    if (reg_index > crss_pkg::LAST_REG_INDEX)
      rd_byte = crss_pkg::UNMAPPED_READ;
    else if (reg_index == crss_pkg::FAULT_REG_INDEX)
      rd_byte = fault_hist_r;
    else
      rd_byte = bank_r[reg_index[3:0]];
  end

  genvar gi;
  generate
    for (gi = 0; gi < crss_pkg::REG_COUNT; gi++)
    begin : g_bank
      always_ff @(posedge clock or negedge reset_n)
      begin
        if (!reset_n)
          bank_r[gi] <= crss_pkg::REG_RESET;
        else if (ce && wr_pulse && reg_index == 8'(gi)
                 && reg_index != crss_pkg::FAULT_REG_INDEX)
          bank_r[gi] <= wr_byte;
      end
    end
  endgenerate

  // history latches new faults; a read reloads with live state, new wins
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      fault_hist_r <= 8'h00;
    else if (ce)
    begin
      if (fault_rd_pulse)
        fault_hist_r <= fault_live;
      else
        fault_hist_r <= fault_hist_r | fault_live;
    end
  end

  // --------------------------------------------------------------
  // write fifo: received data bytes queue before the bank
  // --------------------------------------------------------------
  logic       rxq_valid;
  logic       rxq_ready;
  logic [7:0] rxq_data;
  logic       rxq_push;
  logic       rxq_out_valid;

  crss_fifo #(.WIDTH(crss_pkg::DATA_W), .DEPTH(crss_pkg::FIFO_DEPTH)) u_rxq (
    .clock     (clock),
    .reset_n   (reset_n),
    .ce        (ce),
    .clear     (1'b0),
    .in_valid  (rxq_valid),
    .in_ready  (rxq_ready),
    .in_data   (rxq_data),
    .out_valid (rxq_out_valid),
    .out_ready (1'b1),
    .out_data  (wr_byte)
  );
  assign wr_pulse  = rxq_out_valid;
  assign rxq_valid = rxq_push;

  // --------------------------------------------------------------
  // bit engine
  // --------------------------------------------------------------
  crss_pkg::crss_state_e state_r;
  logic [7:0] shift_r;
  logic [3:0] bitcnt_r;
  logic       idx_phase_r;
  logic       sda_drive_r;
  logic       ack_ok;

  assign rxq_data = shift_r;
  // full fifo refuses the byte with a not acknowledge
  assign ack_ok   = rxq_ready;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      busy <= 1'b0;
    else if (ce)
    begin
      if (start_det)
        busy <= 1'b1;
      else if (stop_det)
        busy <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r        <= crss_pkg::CRSS_IDLE;
      shift_r        <= 8'h00;
      bitcnt_r       <= 4'h0;
      idx_phase_r    <= 1'b0;
      reg_index      <= 8'h00;
      sda_drive_r    <= 1'b0;
      rxq_push       <= 1'b0;
      fault_rd_pulse <= 1'b0;
    end
    else if (ce)
    begin
      rxq_push       <= 1'b0;
      fault_rd_pulse <= 1'b0;
      if (start_det)
      begin
        // index kept so a read after repeated start resumes there
        state_r     <= crss_pkg::CRSS_ADDR;
        bitcnt_r    <= 4'h0;
        sda_drive_r <= 1'b0;
      end
      else if (stop_det)
      begin
        state_r     <= crss_pkg::CRSS_IDLE;
        sda_drive_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          crss_pkg::CRSS_IDLE:
            sda_drive_r <= 1'b0;
          crss_pkg::CRSS_ADDR, crss_pkg::CRSS_RXB:
          begin
            if (scl_rise)
            begin
              shift_r  <= {shift_r[6:0], sda_s};
              bitcnt_r <= bitcnt_r + 4'h1;
            end
            else if (scl_fall && bitcnt_r == 4'h8)
            begin
              bitcnt_r <= 4'h0;
              if (state_r == crss_pkg::CRSS_ADDR)
              begin
                if (shift_r[7:1] == TARGET_ADDR)
                begin
                  sda_drive_r <= 1'b1;
                  state_r     <= crss_pkg::CRSS_AACK;
                  idx_phase_r <= !shift_r[0];
                end
                else
                  state_r <= crss_pkg::CRSS_IDLE;
              end
              else if (idx_phase_r)
              begin
                idx_phase_r <= 1'b0;
                if (shift_r > crss_pkg::LAST_REG_INDEX)
                  state_r <= crss_pkg::CRSS_IDLE;
                else
                begin
                  reg_index   <= shift_r;
                  sda_drive_r <= 1'b1;
                  state_r     <= crss_pkg::CRSS_RACK;
                end
              end
              else if (ack_ok)
              begin
                rxq_push    <= 1'b1;
                sda_drive_r <= 1'b1;
                state_r     <= crss_pkg::CRSS_RACK;
              end
              else
                state_r <= crss_pkg::CRSS_IDLE;
            end
          end
          crss_pkg::CRSS_AACK:
          begin
            if (scl_fall)
            begin
              if (shift_r[0])
              begin
                // direction one: start sending the selected register
                sda_drive_r <= !rd_byte[7];
                shift_r     <= {rd_byte[6:0], 1'b1};
                bitcnt_r    <= 4'h1;
                if (reg_index == crss_pkg::FAULT_REG_INDEX)
                  fault_rd_pulse <= 1'b1;
                state_r     <= crss_pkg::CRSS_TXB;
              end
              else
              begin
                sda_drive_r <= 1'b0;
                state_r     <= crss_pkg::CRSS_RXB;
              end
            end
          end
          crss_pkg::CRSS_RACK:
          begin
            if (scl_fall)
            begin
              sda_drive_r <= 1'b0;
              state_r     <= crss_pkg::CRSS_RXB;
            end
          end
          crss_pkg::CRSS_TXB:
          begin
            if (scl_fall)
            begin
              if (bitcnt_r == 4'h8)
              begin
                sda_drive_r <= 1'b0;
                bitcnt_r    <= 4'h0;
                state_r     <= crss_pkg::CRSS_TACK;
              end
              else
              begin
                sda_drive_r <= !shift_r[7];
                shift_r     <= {shift_r[6:0], 1'b1};
                bitcnt_r    <= bitcnt_r + 4'h1;
              end
            end
          end
          crss_pkg::CRSS_TACK:
          begin
            if (scl_rise)
            begin
              if (sda_s)
                state_r <= crss_pkg::CRSS_IDLE;
              else
                reg_index <= next_index(reg_index);
            end
            else if (scl_fall && reg_index != crss_pkg::FAULT_REG_INDEX)
            begin
              sda_drive_r <= !rd_byte[7];
              shift_r     <= {rd_byte[6:0], 1'b1};
              bitcnt_r    <= 4'h1;
              state_r     <= crss_pkg::CRSS_TXB;
            end
          end
          default:
            state_r <= crss_pkg::CRSS_IDLE;
        endcase
        // write data steps the index once it has been queued
        if (wr_pulse)
          reg_index <= next_index(reg_index);
      end
    end
  end

  // --------------------------------------------------------------
  // pin drive: open drain only, enable low pulls the line low
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sda_oe_n  <= 1'b1;
      sda_out   <= 1'b0;
      scl_oe_n  <= 1'b1;
      scl_out   <= 1'b0;
      wr_strobe <= 1'b0;
      wr_data   <= 8'h00;
    end
    else if (ce)
    begin
      sda_oe_n  <= !sda_drive_r;
      sda_out   <= 1'b0;
      scl_oe_n  <= 1'b1;
      scl_out   <= 1'b0;
      wr_strobe <= wr_pulse;
      wr_data   <= wr_byte;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_sda_only_low : assert property (@(posedge clock) disable iff (!reset_n)
    !sda_out && !scl_out && scl_oe_n)
    else $error("line driven high or clock driven");
  a_stop_idles : assert property (@(posedge clock) disable iff (!reset_n)
    ce && stop_det |=> state_r == crss_pkg::CRSS_IDLE)
    else $error("stop did not idle engine");
  a_start_addr : assert property (@(posedge clock) disable iff (!reset_n)
    ce && start_det |=> state_r == crss_pkg::CRSS_ADDR && bitcnt_r == 4'h0)
    else $error("start did not rearm address");
  a_busy_track : assert property (@(posedge clock) disable iff (!reset_n)
    ce && start_det |=> busy)
    else $error("busy not set on start");
  a_addr_match : assert property (@(posedge clock) disable iff (!reset_n)
    ce && !start_det && !stop_det && state_r == crss_pkg::CRSS_ADDR && scl_fall
    && bitcnt_r == 4'h8 && shift_r[7:1] != TARGET_ADDR
    |=> state_r == crss_pkg::CRSS_IDLE && !sda_drive_r)
    else $error("foreign address acknowledged");
  a_bad_index : assert property (@(posedge clock) disable iff (!reset_n)
    ce && !start_det && !stop_det && state_r == crss_pkg::CRSS_RXB && idx_phase_r
    && scl_fall && bitcnt_r == 4'h8 && shift_r > crss_pkg::LAST_REG_INDEX
    |=> state_r == crss_pkg::CRSS_IDLE && !sda_drive_r)
    else $error("undefined index acknowledged");
  a_unmapped_ff : assert property (@(posedge clock) disable iff (!reset_n)
    reg_index > crss_pkg::LAST_REG_INDEX |-> rd_byte == crss_pkg::UNMAPPED_READ)
    else $error("unmapped read not all ones");
  a_skip_fault : assert property (@(posedge clock) disable iff (!reset_n)
    ce && wr_pulse && !start_det && !stop_det |=> reg_index != crss_pkg::FAULT_REG_INDEX)
    else $error("auto increment landed on fault index");
  a_fault_clear : assert property (@(posedge clock) disable iff (!reset_n)
    ce && fault_rd_pulse |=> fault_hist_r == $past(fault_live))
    else $error("fault history not reloaded on read");
  a_tx_hold_high : assert property (@(posedge clock) disable iff (!reset_n)
    ce && scl_s && scl_d_r && state_r == crss_pkg::CRSS_TXB |=> $stable(sda_drive_r))
    else $error("data changed while clock high");

  c_write_byte : cover property (@(posedge clock) disable iff (!reset_n) wr_strobe);
  c_read_byte  : cover property (@(posedge clock) disable iff (!reset_n)
    state_r == crss_pkg::CRSS_TACK);
  c_fault_read : cover property (@(posedge clock) disable iff (!reset_n) fault_rd_pulse);
  c_rep_start  : cover property (@(posedge clock) disable iff (!reset_n) busy && start_det);
endmodule
`default_nettype wire

/* verif/crss_host_model.sv */
// crss_host_model: behavioural two-wire bus controller facing the target port
// assumes open-drain wiring resolved in the bench; 160 ns bit on a 20 ns clock
`default_nettype none
module crss_host_model (
  input  wire logic clock,    // system clock, paces the bus
  input  wire logic sda_line, // resolved data line
  output var  logic scl_rel,  // 1 releases the bus clock
  output var  logic sda_rel   // 1 releases the data line
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // idle: both lines released, no clocking
  // ------------------------------------------------------------
  initial
  begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  // ------------------------------------------------------------
  // bus phases, a quarter bit each
  // ------------------------------------------------------------
  task automatic q();
    repeat (2) @(negedge clock);
  endtask
  task automatic start();
    sda_rel = 1'b1;
    q();
    scl_rel = 1'b1;
    q();
    sda_rel = 1'b0;
    q();
    scl_rel = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    q();
    scl_rel = 1'b1;
    q();
    sda_rel = 1'b1;
    q();
  endtask
  // sampled late in the high half: the target answers some cycles after a fall
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] r, output logic ack_out);
    logic [8:0] sh;
    sh = {d, ack_in};
    for (int i = 8; i >= 0; i--)
    begin
      sda_rel = sh[i];
      q();
      scl_rel = 1'b1;
      q();
      q();
      sh[i] = sda_line;
      scl_rel = 1'b0;
      q();
    end
    r = sh[8:1];
    ack_out = sh[0];
  endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// tb: self-checking bench for the charger register serial target port
// assumes the design package is compiled first; pull-ups are modelled here
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, reset_n, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic        busy, wr_strobe, scl_rel, sda_rel, a, ce;
  logic [7:0]  fault_live, reg_index, wr_data, r, fh;
  logic [15:0] seed;
  logic [7:0]  mem [12];
  logic [7:0]  wq [$];
  logic [7:0]  eq [$];
  int          n_mismatch, num_checks;
  wire  logic  scl_w = scl_rel & (scl_oe_n | scl_out);
  wire  logic  sda_w = sda_rel & (sda_oe_n | sda_out);
  crss_target u_dut (.clock(clock), .reset_n(reset_n), .ce(ce), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .fault_live(fault_live), .busy(busy), .reg_index(reg_index),
    .wr_strobe(wr_strobe), .wr_data(wr_data));
  crss_host_model u_host (.clock(clock), .sda_line(sda_w), .scl_rel(scl_rel),
    .sda_rel(sda_rel));
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(negedge clock)
    if (wr_strobe === 1'b1)
      wq.push_back(wr_data);
  // ------------------------------------------------------------
  // checking helpers and reference model
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] nxt(input logic [7:0] i);
    return (i == 8'h08) ? 8'h0a : i + 8'h01;
  endfunction
  task automatic head(input logic [7:0] idx);
    u_host.start();
    chk({7'h00, busy}, 8'h01);
    u_host.xfer({crss_pkg::TARGET_ADDR, 1'b0}, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
    u_host.xfer(idx, 1'b1, r, a);
    chk({7'h00, a}, {7'h00, idx > crss_pkg::LAST_REG_INDEX});
  endtask
  task automatic wr(input logic [7:0] idx, input int n);
    head(idx);
    for (int k = 0; k < n; k++)
    begin
      seed = lfsr(seed);
      mem[idx] = seed[7:0];
      eq.push_back(seed[7:0]);
      u_host.xfer(seed[7:0], 1'b1, r, a);
      chk({7'h00, a}, 8'h00);
      idx = nxt(idx);
    end
    u_host.stop();
    repeat (4) @(negedge clock);
    chk({7'h00, busy}, 8'h00);
    chk(reg_index, idx);
    while (eq.size() > 0)
      chk(wq.size() > 0 ? wq.pop_front() : 8'hxx, eq.pop_front());
    chk(8'(wq.size()), 8'h00);
  endtask
  task automatic rd(input logic [7:0] idx, input int n);
    logic [7:0] ex;
    head(idx);
    u_host.start();
    u_host.xfer({crss_pkg::TARGET_ADDR, 1'b1}, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
    for (int k = 0; k < n; k++)
    begin
      u_host.xfer(8'hff, k == n - 1, r, a);
      ex = idx > crss_pkg::LAST_REG_INDEX ? crss_pkg::UNMAPPED_READ :
           idx == crss_pkg::FAULT_REG_INDEX ? fh : mem[idx];
      if (idx == crss_pkg::FAULT_REG_INDEX)
        fh = fault_live;
      chk(r, ex);
      idx = nxt(idx);
    end
    u_host.stop();
    repeat (4) @(negedge clock);
  endtask
  // ------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------
  initial
  begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    results();
  end
  initial
  begin
    reset_n = 1'b0;
    ce = 1'b1;
    fault_live = 8'h00;
    seed = 16'd41327;
    fh = 8'h00;
    foreach (mem[i]) mem[i] = crss_pkg::REG_RESET;
    repeat (5) @(negedge clock);
    chk({busy, scl_oe_n, sda_oe_n, 5'h00}, 8'h60);
    chk(reg_index, 8'h00);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    wr(8'h07, 3);
    rd(8'h07, 3);
    $display("test auto increment done");
    wr(8'h00, 2);
    rd(8'h0a, 3);
    $display("test top of bank done");
    u_host.start();
    u_host.xfer({crss_pkg::TARGET_ADDR ^ 7'h01, 1'b0}, 1'b1, r, a);
    chk({7'h00, a}, 8'h01);
    u_host.stop();
    head(8'h0c);
    u_host.stop();
    rd(8'h00, 1);
    $display("test refusals done");
    fault_live = seed[15:8] | 8'h01;
    fh = fh | fault_live;
    repeat (2) @(negedge clock);
    fault_live = 8'h00;
    rd(8'h09, 1);
    rd(8'h09, 1);
    // a fault seen only while the enable is low must not reach the history
    ce = 1'b0;
    fault_live = 8'h80;
    repeat (2) @(negedge clock);
    fault_live = 8'h00;
    ce = 1'b1;
    rd(8'h09, 1);
    $display("test fault history done");
    results();
  end
endmodule
`default_nettype wire
